// ### design/csf_pkg.sv
package csf_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Register indexes; byte address is four times the index
  localparam int STAT_IDX = 3;
  localparam int CFG_IDX = 1;
  localparam int TMR_IDX = 2;

  ////////////////////////////////////////////////////////////////////////////
  // Status register field positions
  localparam int BIT_C = 0;
  localparam int BIT_DC = 1;
  localparam int BIT_Z = 2;
  localparam int BIT_PD = 3;
  localparam int BIT_TO = 4;
  localparam int BIT_RP0 = 5;
  localparam int BIT_RP1 = 6;
  localparam int BIT_IRP = 7;

  // Prescaler configuration field positions
  localparam int CFG_RATE_LSB = 0;
  localparam int CFG_ASSIGN_BIT = 3;

  ////////////////////////////////////////////////////////////////////////////
  // Reset values
  localparam logic [7:0] STAT_RESET = 8'h18;
  localparam logic [3:0] CFG_RESET = 4'hF;
  localparam logic [7:0] TMR_RESET = 8'h00;

  ////////////////////////////////////////////////////////////////////////////
  // Data memory geometry
  localparam int FILE_ADDR_W = 7;
  localparam int BANK_BYTES = 128;

  ////////////////////////////////////////////////////////////////////////////
  // Operations presented by the core
  typedef enum logic [3:0] {
    OP_NOP,
    OP_ADD,
    OP_SUB,
    OP_AND,
    OP_IOR,
    OP_XOR,
    OP_CLR,
    OP_INC,
    OP_DEC,
    OP_BSET,
    OP_BCLR,
    OP_SWAP,
    OP_MOVE,
    OP_WDCLR,
    OP_SLEEP
  } csf_op_type;

endpackage

// ### design/csf_alu.sv
`timescale 1ns/1ns
module csf_alu (
  input wire csf_pkg::csf_op_type op,
  input wire logic [2:0] bit_sel,
  input wire logic [7:0] acc,
  input wire logic [7:0] opnd,
  output logic [7:0] result,
  output logic [2:0] flags,
  output logic [2:0] affect
);

  logic [8:0] add9;
  logic [4:0] add5;
  logic [8:0] sub9;
  logic [4:0] sub5;
  logic carry;
  logic nib_carry;

  assign add9 = {1'b0, opnd} + {1'b0, acc};
  assign add5 = {1'b0, opnd[3:0]} + {1'b0, acc[3:0]};
  // Subtract by adding the complement: carry out of one means no borrow
  assign sub9 = {1'b0, opnd} + {1'b0, ~acc} + 9'h001;
  assign sub5 = {1'b0, opnd[3:0]} + {1'b0, ~acc[3:0]} + 5'h01;

  always_comb begin
    result = opnd;
    carry = 1'b0;
    nib_carry = 1'b0;
    affect = 3'b000;
    case (op)
      csf_pkg::OP_ADD: begin
        result = add9[7:0];
        carry = add9[8];
        nib_carry = add5[4];
        affect = 3'b111;
      end
      csf_pkg::OP_SUB: begin
        result = sub9[7:0];
        carry = sub9[8];
        nib_carry = sub5[4];
        affect = 3'b111;
      end
      csf_pkg::OP_AND: begin
        result = acc & opnd;
        affect = 3'b100;
      end
      csf_pkg::OP_IOR: begin
        result = acc | opnd;
        affect = 3'b100;
      end
      csf_pkg::OP_XOR: begin
        result = acc ^ opnd;
        affect = 3'b100;
      end
      csf_pkg::OP_CLR: begin
        result = 8'h00;
        affect = 3'b100;
      end
      csf_pkg::OP_INC: begin
        result = opnd + 8'h01;
        affect = 3'b100;
      end
      csf_pkg::OP_DEC: begin
        result = opnd - 8'h01;
        affect = 3'b100;
      end
      csf_pkg::OP_BSET: result = opnd | (8'h01 << bit_sel);
      csf_pkg::OP_BCLR: result = opnd & ~(8'h01 << bit_sel);
      csf_pkg::OP_SWAP: result = {opnd[3:0], opnd[7:4]};
      csf_pkg::OP_MOVE: result = acc;
      default: result = opnd;
    endcase
  end

  assign flags = {result == 8'h00, nib_carry, carry};

endmodule

// ### design/csf_prescaler.sv
`timescale 1ns/1ns
module csf_prescaler #(
  parameter int WIDTH = 8
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic timer_tick,
  input wire logic wdt_tick,
  input wire logic assign_wdt,
  input wire logic [2:0] rate,
  input wire logic wdt_clear,
  output logic timer_inc,
  output logic wdt_inc
);

  logic [WIDTH-1:0] count_reg;
  logic timer_inc_reg;
  logic wdt_inc_reg;

  // Mask of low count bits that must all be one for a divided tick
  function automatic logic [WIDTH-1:0] ratio_mask(input logic [2:0] r, input logic extra);
    logic [WIDTH:0] one_hot;
    one_hot = (WIDTH+1)'(1) << ({1'b0, r} + {3'b000, extra});
    ratio_mask = one_hot[WIDTH-1:0] - WIDTH'(1);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // One divider, fed by whichever user owns it
  wire src_tick = assign_wdt ? wdt_tick : timer_tick;
  wire [WIDTH-1:0] mask = ratio_mask(rate, ~assign_wdt);
  wire div_hit = src_tick & ((count_reg & mask) == mask);
  wire clear = wdt_clear & assign_wdt;
  // Timer goes 1:1 only while the divider is lent to the watchdog
  wire timer_next = assign_wdt ? timer_tick : div_hit;
  wire wdt_next = assign_wdt ? div_hit : wdt_tick;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      count_reg <= '0;
      timer_inc_reg <= 1'b0;
      wdt_inc_reg <= 1'b0;
    end else begin
      count_reg <= clear ? '0 : count_reg + WIDTH'(src_tick);
      timer_inc_reg <= timer_next;
      wdt_inc_reg <= wdt_next;
    end
  end

  assign timer_inc = timer_inc_reg;
  assign wdt_inc = wdt_inc_reg;

  ////////////////////////////////////////////////////////////////////////////
  property p_wdt_bypass;
    @(posedge clock) disable iff (!rst_n)
    (!assign_wdt && wdt_tick) |=> wdt_inc;
  endproperty
  a_wdt_bypass: assert property (p_wdt_bypass) else $error("watchdog tick lost");

  property p_timer_divides;
    @(posedge clock) disable iff (!rst_n)
    (!assign_wdt) ##1 (!assign_wdt && timer_inc && !clear) |=> !timer_inc;
  endproperty
  a_timer_divides: assert property (p_timer_divides) else $error("timer not divided");

  property p_timer_direct;
    @(posedge clock) disable iff (!rst_n)
    (assign_wdt && timer_tick) |=> timer_inc;
  endproperty
  a_timer_direct: assert property (p_timer_direct) else $error("timer not 1:1");

endmodule

// ### design/csf_status_reg.sv
`timescale 1ns/1ns
// How it works
// - Any instruction may target the status register
// - Flag-updating ops ignore written flag bits
// - Those flags come from the operation's logic
// - Watchdog and sleep flags are read-only
// - Clear op zeroes top three, sets zero
// - Subtract carries are inverted borrows
// - One prescaler, owned by timer or watchdog
// - Timer runs 1:1 only with watchdog ownership
// - Bank bits extend the 128-byte bank address
// - Status decoded at same offset every bank
module csf_status_reg #(
  parameter int ADDR_W = 8,
  parameter int PRESC_W = 8,
  parameter int WDT_W = 8
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic exec_valid,
  input wire csf_pkg::csf_op_type exec_op,
  input wire logic [csf_pkg::FILE_ADDR_W-1:0] exec_file_addr,
  input wire logic [2:0] exec_bit,
  input wire logic exec_to_file,
  input wire logic [7:0] exec_acc,
  input wire logic [7:0] exec_file_data,
  input wire logic [7:0] fsr_value,
  input wire logic timer_tick,
  input wire logic wdt_tick,
  output logic [7:0] result,
  output logic result_valid,
  output logic result_to_file,
  output logic [csf_pkg::FILE_ADDR_W+1:0] direct_addr,
  output logic [8:0] indirect_addr,
  output logic [7:0] alu_flags_and_bank_select,
  output logic [7:0] timer_zero,
  output logic watchdog_expired
);

  localparam logic [ADDR_W-1:0] STAT_ADDR = ADDR_W'(4 * csf_pkg::STAT_IDX);
  localparam logic [ADDR_W-1:0] CFG_ADDR = ADDR_W'(4 * csf_pkg::CFG_IDX);
  localparam logic [ADDR_W-1:0] TMR_ADDR = ADDR_W'(4 * csf_pkg::TMR_IDX);

  // Status sits at the same offset in every bank, whatever the bank bits
  function automatic logic is_status_file(input logic [csf_pkg::FILE_ADDR_W-1:0] a);
    is_status_file = (a == csf_pkg::FILE_ADDR_W'(csf_pkg::STAT_IDX));
  endfunction

  logic [7:0] status_reg;
  logic [3:0] cfg_reg;
  logic [7:0] tmr_reg;
  logic [WDT_W-1:0] wdt_cnt_reg;
  logic wdt_expire_reg;
  logic [31:0] prdata_reg;
  logic pready_reg;
  logic pslverr_reg;
  logic [7:0] result_reg;
  logic result_valid_reg;
  logic result_to_file_reg;
  logic [csf_pkg::FILE_ADDR_W+1:0] direct_addr_reg;
  logic [8:0] indirect_addr_reg;
  logic [7:0] alu_result;
  logic [2:0] alu_flag;
  logic [2:0] alu_affect;
  logic timer_inc;
  logic wdt_inc;

  ////////////////////////////////////////////////////////////////////////////
  // APB decode
  wire setup = psel & ~penable;
  wire wr_acc = psel & penable & pwrite & pready_reg;
  wire hit_stat = (paddr == STAT_ADDR);
  wire hit_cfg = (paddr == CFG_ADDR);
  wire hit_tmr = (paddr == TMR_ADDR);
  wire mapped = hit_stat | hit_cfg | hit_tmr;
  wire [31:0] rd_mux = hit_stat ? {24'h000000, status_reg} :
                       hit_cfg ? {28'h0000000, cfg_reg} :
                       hit_tmr ? {24'h000000, tmr_reg} : 32'h00000000;
  wire apb_stat_wr = wr_acc & hit_stat;
  wire apb_cfg_wr = wr_acc & hit_cfg;

  ////////////////////////////////////////////////////////////////////////////
  // Operation and flag logic
  wire op_is_stat = is_status_file(exec_file_addr);
  wire [7:0] opnd = op_is_stat ? status_reg : exec_file_data;

  csf_alu u_alu (
    .op(exec_op),
    .bit_sel(exec_bit),
    .acc(exec_acc),
    .opnd(opnd),
    .result(alu_result),
    .flags(alu_flag),
    .affect(alu_affect)
  );

  wire exec_hit = exec_valid & exec_to_file & op_is_stat;
  wire collide = exec_hit & (|alu_affect);
  wire wr_any = exec_hit | apb_stat_wr;
  wire [7:0] wr_data = exec_hit ? alu_result : pwdata[7:0];
  wire [2:0] upper_next = wr_any ? wr_data[7:5] : status_reg[7:5];
  // A flag-updating op never stores its result into the flag bits
  wire [2:0] flag_base = (wr_any & ~collide) ? wr_data[2:0] : status_reg[2:0];
  wire [2:0] flag_mask = exec_valid ? alu_affect : 3'b000;
  wire [2:0] flag_next = (alu_flag & flag_mask) | (flag_base & ~flag_mask);

  ////////////////////////////////////////////////////////////////////////////
  // Watchdog and sleep flags: events only, never the written data
  wire op_wdclr = exec_valid & (exec_op == csf_pkg::OP_WDCLR);
  wire op_sleep = exec_valid & (exec_op == csf_pkg::OP_SLEEP);
  wire wdt_clear = op_wdclr | op_sleep;
  wire wdt_expire = wdt_inc & (&wdt_cnt_reg) & ~wdt_clear;
  wire to_next = wdt_expire_reg ? 1'b0 :
                 wdt_clear ? 1'b1 : status_reg[csf_pkg::BIT_TO];
  wire pd_next = op_wdclr ? 1'b1 :
                 op_sleep ? 1'b0 : status_reg[csf_pkg::BIT_PD];
  wire [7:0] status_next = {upper_next, to_next, pd_next, flag_next};
  wire [WDT_W-1:0] wdt_cnt_next = wdt_clear ? '0 : wdt_cnt_reg + WDT_W'(wdt_inc);

  ////////////////////////////////////////////////////////////////////////////
  // Shared prescaler
  csf_prescaler #(
    .WIDTH(PRESC_W)
  ) u_prescaler (
    .clock(clock),
    .rst_n(rst_n),
    .timer_tick(timer_tick),
    .wdt_tick(wdt_tick),
    .assign_wdt(cfg_reg[csf_pkg::CFG_ASSIGN_BIT]),
    .rate(cfg_reg[csf_pkg::CFG_RATE_LSB +: 3]),
    .wdt_clear(wdt_clear),
    .timer_inc(timer_inc),
    .wdt_inc(wdt_inc)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Bank addressing: 7-bit field plus two bank bits spans four 128-byte banks
  wire [csf_pkg::FILE_ADDR_W+1:0] direct_next =
    {status_reg[csf_pkg::BIT_RP1], status_reg[csf_pkg::BIT_RP0], exec_file_addr};
  wire [8:0] indirect_next = {status_reg[csf_pkg::BIT_IRP], fsr_value};

  ////////////////////////////////////////////////////////////////////////////
  // Registers
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      status_reg <= csf_pkg::STAT_RESET;
      cfg_reg <= csf_pkg::CFG_RESET;
      tmr_reg <= csf_pkg::TMR_RESET;
      wdt_cnt_reg <= '0;
      wdt_expire_reg <= 1'b0;
    end else begin
      status_reg <= status_next;
      cfg_reg <= apb_cfg_wr ? pwdata[3:0] : cfg_reg;
      tmr_reg <= tmr_reg + 8'(timer_inc);
      wdt_cnt_reg <= wdt_cnt_next;
      wdt_expire_reg <= wdt_expire;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      prdata_reg <= 32'h00000000;
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
    end else begin
      prdata_reg <= setup ? rd_mux : prdata_reg;
      pready_reg <= 1'b1;
      pslverr_reg <= setup ? ~mapped : pslverr_reg;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      result_reg <= 8'h00;
      result_valid_reg <= 1'b0;
      result_to_file_reg <= 1'b0;
      direct_addr_reg <= '0;
      indirect_addr_reg <= 9'h000;
    end else begin
      result_reg <= exec_valid ? alu_result : result_reg;
      result_valid_reg <= exec_valid;
      result_to_file_reg <= exec_valid & exec_to_file & ~op_is_stat;
      direct_addr_reg <= exec_valid ? direct_next : direct_addr_reg;
      indirect_addr_reg <= indirect_next;
    end
  end

  assign prdata = prdata_reg;
  assign pready = pready_reg;
  assign pslverr = pslverr_reg;
  assign result = result_reg;
  assign result_valid = result_valid_reg;
  assign result_to_file = result_to_file_reg;
  assign direct_addr = direct_addr_reg;
  assign indirect_addr = indirect_addr_reg;
  assign alu_flags_and_bank_select = status_reg;
  assign timer_zero = tmr_reg;
  assign watchdog_expired = wdt_expire_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  property p_flag_write_blocked;
    @(posedge clock) disable iff (!rst_n)
    (collide && !alu_affect[1]) |=> status_reg[1] == $past(status_reg[1]);
  endproperty
  a_flag_write_blocked: assert property (p_flag_write_blocked)
    else $error("written value reached a flag");

  property p_flag_from_logic;
    @(posedge clock) disable iff (!rst_n)
    (exec_valid && alu_affect[2]) |=> status_reg[csf_pkg::BIT_Z] == $past(alu_flag[2]);
  endproperty
  a_flag_from_logic: assert property (p_flag_from_logic)
    else $error("zero flag not from logic");

  property p_ro_flags;
    @(posedge clock) disable iff (!rst_n)
    (apb_stat_wr && !exec_valid && !wdt_expire_reg) |=> $stable(status_reg[4:3]);
  endproperty
  a_ro_flags: assert property (p_ro_flags)
    else $error("software changed read-only flag");

  property p_clear_status;
    @(posedge clock) disable iff (!rst_n)
    (exec_hit && exec_op == csf_pkg::OP_CLR && !wdt_expire_reg)
      |=> status_reg[7:5] == 3'b000 && status_reg[2] && $stable(status_reg[4:3])
          && status_reg[1:0] == $past(status_reg[1:0]);
  endproperty
  a_clear_status: assert property (p_clear_status)
    else $error("clear of status wrong");

  property p_borrow;
    @(posedge clock) disable iff (!rst_n)
    (exec_valid && exec_op == csf_pkg::OP_SUB)
      |=> status_reg[csf_pkg::BIT_C] == ($past(opnd) >= $past(exec_acc));
  endproperty
  a_borrow: assert property (p_borrow)
    else $error("borrow polarity wrong");

  property p_direct_bank;
    @(posedge clock) disable iff (!rst_n)
    exec_valid |=> direct_addr == {$past(status_reg[6:5]), $past(exec_file_addr)};
  endproperty
  a_direct_bank: assert property (p_direct_bank)
    else $error("direct address wrong");

  property p_any_bank_move;
    @(posedge clock) disable iff (!rst_n)
    (exec_valid && exec_to_file && exec_op == csf_pkg::OP_MOVE && op_is_stat)
      |=> status_reg[7:5] == $past(exec_acc[7:5]) && status_reg[2:0] == $past(exec_acc[2:0]);
  endproperty
  a_any_bank_move: assert property (p_any_bank_move)
    else $error("status move lost");

  property p_sleep_flags;
    @(posedge clock) disable iff (!rst_n)
    (op_sleep && !wdt_expire_reg) |=> status_reg[csf_pkg::BIT_TO] && !status_reg[csf_pkg::BIT_PD];
  endproperty
  a_sleep_flags: assert property (p_sleep_flags)
    else $error("sleep flags wrong");

  property p_expiry_clears;
    @(posedge clock) disable iff (!rst_n)
    wdt_expire |=> watchdog_expired ##1 !status_reg[csf_pkg::BIT_TO];
  endproperty
  a_expiry_clears: assert property (p_expiry_clears)
    else $error("expiry flag not cleared");

  property p_wdclr_flags;
    @(posedge clock) disable iff (!rst_n)
    (op_wdclr && !wdt_expire_reg) |=> status_reg[csf_pkg::BIT_TO] && status_reg[csf_pkg::BIT_PD];
  endproperty
  a_wdclr_flags: assert property (p_wdclr_flags)
    else $error("watchdog clear flags wrong");

  property p_apb_status_write;
    @(posedge clock) disable iff (!rst_n)
    (apb_stat_wr && !exec_valid)
      |=> status_reg[7:5] == $past(pwdata[7:5]) && status_reg[2:0] == $past(pwdata[2:0]);
  endproperty
  a_apb_status_write: assert property (p_apb_status_write)
    else $error("software status write lost");

  property p_status_not_external;
    @(posedge clock) disable iff (!rst_n)
    (exec_valid && exec_to_file && op_is_stat) |=> !result_to_file;
  endproperty
  a_status_not_external: assert property (p_status_not_external)
    else $error("status write sent to file memory");

  property p_timer_count;
    @(posedge clock) disable iff (!rst_n)
    timer_inc |=> timer_zero == $past(timer_zero) + 8'h01;
  endproperty
  a_timer_count: assert property (p_timer_count)
    else $error("timer did not count");

  property p_indirect_bank;
    @(posedge clock) disable iff (!rst_n)
    1'b1 |=> indirect_addr == {$past(status_reg[csf_pkg::BIT_IRP]), $past(fsr_value)};
  endproperty
  a_indirect_bank: assert property (p_indirect_bank)
    else $error("indirect address wrong");

  c_collide: cover property (@(posedge clock) disable iff (!rst_n) collide);
  c_clear: cover property (@(posedge clock) disable iff (!rst_n)
    exec_hit && exec_op == csf_pkg::OP_CLR);
  c_sleep: cover property (@(posedge clock) disable iff (!rst_n) op_sleep);
  c_expire: cover property (@(posedge clock) disable iff (!rst_n) wdt_expire_reg);

endmodule

// ### bench/csf_status_reg_tb.sv
`timescale 1ns/1ns
module csf_status_reg_tb;
  typedef struct packed {
    logic [7:0] pre;
    csf_pkg::csf_op_type op;
    logic [6:0] fa;
    logic [2:0] bs;
    logic tf;
    logic [7:0] acc;
    logic [7:0] fd;
    logic [7:0] res;
    logic [7:0] st;
  } csf_row_type;

  logic clock, rst_n, psel, penable, pwrite, pready, pslverr, err;
  logic exec_valid, exec_to_file, timer_tick, wdt_tick;
  logic result_valid, result_to_file, watchdog_expired;
  logic [7:0] paddr, exec_acc, exec_file_data, fsr_value, result, timer_zero;
  logic [7:0] alu_flags_and_bank_select;
  logic [31:0] pwdata, prdata, rd;
  csf_pkg::csf_op_type exec_op;
  logic [6:0] exec_file_addr;
  logic [2:0] exec_bit;
  logic [8:0] direct_addr, indirect_addr;
  int fail_count, n_compared, wd_seen;

  // Pre-write status, op, file addr, bit, to file, acc, file data, result, status
  csf_row_type rows [15] = '{
    '{8'h18, csf_pkg::OP_ADD, 7'h20, 3'h0, 1'b0, 8'h0F, 8'h01, 8'h10, 8'h1A},
    '{8'h18, csf_pkg::OP_SUB, 7'h20, 3'h0, 1'b0, 8'h03, 8'h05, 8'h02, 8'h1B},
    '{8'h1B, csf_pkg::OP_SUB, 7'h20, 3'h0, 1'b0, 8'h05, 8'h03, 8'hFE, 8'h18},
    '{8'h18, csf_pkg::OP_SUB, 7'h20, 3'h0, 1'b0, 8'h01, 8'h10, 8'h0F, 8'h19},
    '{8'hFB, csf_pkg::OP_CLR, 7'h03, 3'h0, 1'b1, 8'h00, 8'h00, 8'h00, 8'h1F},
    '{8'h18, csf_pkg::OP_ADD, 7'h03, 3'h0, 1'b1, 8'h48, 8'hFF, 8'h60, 8'h7A},
    '{8'h18, csf_pkg::OP_MOVE, 7'h03, 3'h0, 1'b1, 8'hA5, 8'h00, 8'hA5, 8'hBD},
    '{8'h18, csf_pkg::OP_BSET, 7'h03, 3'h6, 1'b1, 8'h00, 8'h00, 8'h58, 8'h58},
    '{8'h18, csf_pkg::OP_BCLR, 7'h03, 3'h3, 1'b1, 8'h00, 8'h00, 8'h10, 8'h18},
    '{8'h39, csf_pkg::OP_SWAP, 7'h03, 3'h0, 1'b1, 8'h00, 8'h00, 8'h93, 8'h9B},
    '{8'h18, csf_pkg::OP_AND, 7'h20, 3'h0, 1'b1, 8'hF0, 8'h0F, 8'h00, 8'h1C},
    '{8'h1B, csf_pkg::OP_INC, 7'h20, 3'h0, 1'b0, 8'h00, 8'hFF, 8'h00, 8'h1F},
    '{8'h18, csf_pkg::OP_DEC, 7'h20, 3'h0, 1'b0, 8'h00, 8'h01, 8'h00, 8'h1C},
    '{8'h18, csf_pkg::OP_IOR, 7'h20, 3'h0, 1'b0, 8'h12, 8'h40, 8'h52, 8'h18},
    '{8'h1C, csf_pkg::OP_XOR, 7'h20, 3'h0, 1'b0, 8'h33, 8'h30, 8'h03, 8'h18}
  };

  csf_status_reg #(.WDT_W(3)) dut (.clock(clock), .rst_n(rst_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .exec_valid(exec_valid), .exec_op(exec_op),
    .exec_file_addr(exec_file_addr), .exec_bit(exec_bit), .exec_to_file(exec_to_file),
    .exec_acc(exec_acc), .exec_file_data(exec_file_data), .fsr_value(fsr_value),
    .timer_tick(timer_tick), .wdt_tick(wdt_tick), .result(result),
    .result_valid(result_valid), .result_to_file(result_to_file),
    .direct_addr(direct_addr), .indirect_addr(indirect_addr),
    .alu_flags_and_bank_select(alu_flags_and_bank_select), .timer_zero(timer_zero),
    .watchdog_expired(watchdog_expired));

  ////////////////////////////////////////////////////////////////////////////
  always #20 clock = ~clock;

  always @(posedge clock) begin
    if (watchdog_expired === 1'b1) begin
      wd_seen <= wd_seen + 1;
    end
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      fail_count++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic conclude();
    $display("compared %0d, mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  task automatic apb(input logic wr, input logic [7:0] addr, input logic [31:0] wd);
    int n;
    n = 0;
    @(posedge clock);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= addr;
    pwdata <= wd;
    @(posedge clock);
    penable <= 1'b1;
    do begin
      @(posedge clock);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) begin
      fail_count++;
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic exec(input csf_row_type r);
    @(posedge clock);
    exec_valid <= 1'b1;
    exec_op <= r.op;
    exec_file_addr <= r.fa;
    exec_bit <= r.bs;
    exec_to_file <= r.tf;
    exec_acc <= r.acc;
    exec_file_data <= r.fd;
    @(posedge clock);
    exec_valid <= 1'b0;
    #1;
  endtask

  task automatic tick(input logic to_timer, input int n);
    repeat (n) begin
      @(posedge clock);
      timer_tick <= to_timer;
      wdt_tick <= ~to_timer;
      @(posedge clock);
      timer_tick <= 1'b0;
      wdt_tick <= 1'b0;
    end
    repeat (6) @(posedge clock);
    #1;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (5000) @(posedge clock);
    fail_count++;
    conclude();
  end

  initial begin
    clock = 1'b0;
    rst_n = 1'b0;
    {psel, penable, pwrite, exec_valid, exec_to_file, timer_tick, wdt_tick} = '0;
    {paddr, exec_acc, exec_file_data, exec_bit, exec_file_addr, pwdata} = '0;
    exec_op = csf_pkg::OP_NOP;
    fsr_value = 8'h44;
    fail_count = 0;
    n_compared = 0;
    wd_seen = 0;
    repeat (5) @(posedge clock);
    #1;
    check(alu_flags_and_bank_select, 32'h18);
    check(pready, 32'h0);
    @(posedge clock);
    rst_n <= 1'b1;
    $display("reset test done");

    apb(1'b0, 8'h0C, 32'h0);
    check(rd, 32'h18);
    apb(1'b0, 8'h04, 32'h0);
    check(rd, 32'hF);
    apb(1'b0, 8'h10, 32'h0);
    check({err, rd[30:0]}, 32'h80000000);
    apb(1'b1, 8'h0C, 32'h0);
    apb(1'b0, 8'h0C, 32'h0);
    check(rd, 32'h18);
    apb(1'b1, 8'h0C, 32'hE0);
    apb(1'b0, 8'h0C, 32'h0);
    check(rd, 32'hF8);
    $display("register test done");

    foreach (rows[i]) begin
      apb(1'b1, 8'h0C, {24'h0, rows[i].pre});
      exec(rows[i]);
      check(result, rows[i].res);
      check(result_valid, 32'h1);
      check(result_to_file, rows[i].tf && rows[i].fa != 7'h03);
      check(alu_flags_and_bank_select, rows[i].st);
      check(direct_addr, {rows[i].pre[6:5], rows[i].fa});
      @(posedge clock);
      #1;
      check(indirect_addr, {rows[i].st[7], fsr_value});
    end
    $display("table test done");

    // Watchdog owns the prescaler out of reset, so the timer runs undivided
    tick(1'b1, 3);
    check(timer_zero, 32'h3);
    apb(1'b1, 8'h04, 32'h0);
    tick(1'b1, 4);
    check(timer_zero, 32'h5);
    apb(1'b1, 8'h08, 32'h55);
    apb(1'b0, 8'h08, 32'h0);
    check(rd, 32'h5);
    $display("prescaler test done");

    // Three-bit watchdog at 1:1 overflows on the eighth event
    tick(1'b0, 7);
    check(wd_seen, 32'h0);
    check(alu_flags_and_bank_select[4], 32'h1);
    tick(1'b0, 1);
    check(wd_seen, 32'h1);
    check(alu_flags_and_bank_select[4], 32'h0);
    exec('{8'h00, csf_pkg::OP_SLEEP, 7'h20, 3'h0, 1'b0, 8'h00, 8'h00, 8'h00, 8'h00});
    check(alu_flags_and_bank_select[4:3], 32'h2);
    tick(1'b0, 7);
    exec('{8'h00, csf_pkg::OP_WDCLR, 7'h20, 3'h0, 1'b0, 8'h00, 8'h00, 8'h00, 8'h00});
    check(alu_flags_and_bank_select[4:3], 32'h3);
    tick(1'b0, 7);
    check(wd_seen, 32'h1);
    $display("watchdog test done");
    conclude();
  end
endmodule
